// ---- rtl/l2wp_top.sv ----
`timescale 1ns/1ps
`include "l2wp_consts.svh"
module l2wp_top #(
  parameter bit ENLARGED = 1'b0
) (
  input  wire logic                       clk_sys,
  input  wire logic                       rstn,
  input  wire logic                       clk_link,
  input  wire logic [2:0]                 l2_clock_ratio_sel,
  input  wire logic [1:0]                 l2_clock_phase_tap,
  input  wire logic [2:0]                 l2_capacity_sel,
  input  wire logic                       l2_line_length_sel,
  input  wire logic                       req_valid,
  input  wire logic [`L2WP_PA_W-1:0]      req_phys_addr,
  output logic                            req_ready,
  output logic                            resp_valid,
  output logic [1:0]                      resp_outcome,
  output logic                            resp_way,
  output logic [`L2WP_N_COPIES-1:0]       l2_port_clock,
  output logic [`L2WP_N_COPIES-1:0]       l2_port_clock_n,
  output logic [`L2WP_LINES_W-1:0]        l2_index_lines,
  output logic                            l2_data_way_sel,
  output logic                            l2_tag_index_low_bit,
  output logic                            l2_tag_way_sel,
  input  wire logic [`L2WP_TAG_W-1:0]     l2_tag_bus
);
  l2wp_pt_if pt ();

  l2wp_clk_gen u_clk_gen (
    .clk_sys         (clk_sys),
    .rstn            (rstn),
    .ratio_sel       (l2_clock_ratio_sel),
    .tap_sel         (l2_clock_phase_tap),
    .l2_port_clock   (l2_port_clock),
    .l2_port_clock_n (l2_port_clock_n)
  );

  l2wp_pred_table #(.ENLARGED(ENLARGED)) u_table (
    .clk_link (clk_link),
    .pt       (pt)
  );

  // Lines used for a capacity code: 14 + code low bits
  function automatic logic [`L2WP_LINES_W-1:0] line_mask(
    input logic [2:0] sz);
    logic [`L2WP_LINES_W-1:0] m;
    m = '1;
    line_mask = m >> (`L2WP_SIZE_MAX - sz);
  endfunction

  function automatic logic tag_hit(
    input logic [`L2WP_TAG_W-1:0]  tag,
    input logic [`L2WP_PA_W-1:0]   pa);
    tag_hit = (tag[`L2WP_TB_PTAG_HI:`L2WP_TB_PTAG_LO] ==
               pa[`L2WP_PTAG_HI:`L2WP_PTAG_LO]) &&
              (tag[1:0] != `L2WP_ST_INVALID);
  endfunction

  // Core domain: request capture and answer
  logic [`L2WP_PA_W-1:0] addr_q;
  logic                  req_tgl_q;
  logic                  done_s1_q, done_s2_q, done_s3_q;
  logic                  done_evt_w;
  logic                  take_w;
  logic [1:0]            outc_q;
  logic                  fill_way_q;
  logic                  done_tgl_q;

  assign take_w     = req_valid && req_ready;
  assign done_evt_w = done_s2_q ^ done_s3_q;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      addr_q       <= '0;
      req_tgl_q    <= 1'b0;
      req_ready    <= 1'b1;
      resp_valid   <= 1'b0;
      resp_outcome <= 2'h0;
      resp_way     <= 1'b0;
      done_s1_q    <= 1'b0;
      done_s2_q    <= 1'b0;
      done_s3_q    <= 1'b0;
    end else begin
      done_s1_q  <= done_tgl_q;
      done_s2_q  <= done_s1_q;
      done_s3_q  <= done_s2_q;
      resp_valid <= done_evt_w;
      if (take_w) begin
        addr_q    <= req_phys_addr;
        req_tgl_q <= ~req_tgl_q;
        req_ready <= 1'b0;
      end else if (done_evt_w) begin
        req_ready <= 1'b1;
      end
      if (done_evt_w) begin
        resp_outcome <= outc_q;
        resp_way     <= fill_way_q;
      end
    end
  end

  // Link domain: reset release and mode straps
  logic       lrst_s1_q, lrstn_q;
  logic [2:0] sz_s1_q, sz_q;
  logic       len_s1_q, len_q;
  logic       rq_s1_q, rq_s2_q, rq_s3_q;

  always_ff @(posedge clk_link or negedge rstn) begin
    if (!rstn) begin
      lrst_s1_q <= 1'b0;
      lrstn_q   <= 1'b0;
    end else begin
      lrst_s1_q <= 1'b1;
      lrstn_q   <= lrst_s1_q;
    end
  end

  always_ff @(posedge clk_link or negedge lrstn_q) begin
    if (!lrstn_q) begin
      sz_s1_q  <= 3'h0;
      sz_q     <= 3'h0;
      len_s1_q <= 1'b0;
      len_q    <= 1'b0;
      rq_s1_q  <= 1'b0;
      rq_s2_q  <= 1'b0;
      rq_s3_q  <= 1'b0;
    end else begin
      sz_s1_q  <= l2_capacity_sel;
      sz_q     <= sz_s1_q;
      len_s1_q <= l2_line_length_sel;
      len_q    <= len_s1_q;
      rq_s1_q  <= req_tgl_q;
      rq_s2_q  <= rq_s1_q;
      rq_s3_q  <= rq_s2_q;
    end
  end

  // Address is held by the core domain until the answer returns
  l2wp_pkg::l2wp_state_t     st_q, st_d;
  logic                      req_evt_w;
  logic [2:0]                sz_w;
  logic [`L2WP_LINES_W-1:0]  mask_w, slot_w, base_w;
  logic [`L2WP_PT_IDX_W-1:0] idx13_w, idx_w;
  logic                      top_w;
  logic                      pred_q;
  logic [`L2WP_TAG_W-1:0]    tag_in_q, ptag_q;
  logic                      hit_p_w, hit_a_w, pvalid_w, cmp_w;
  logic                      reacc_w, upd_w;
  logic [`L2WP_LINES_W-1:0]  lines_d;

  assign req_evt_w = rq_s2_q ^ rq_s3_q;
  assign sz_w      = (sz_q > `L2WP_SIZE_MAX) ? `L2WP_SIZE_MAX : sz_q;
  assign mask_w    = line_mask(sz_w);
  assign slot_w    = (line_mask(sz_w) << 1) & ~mask_w;
  assign base_w    = addr_q[`L2WP_LINES_HI:`L2WP_LINES_LO] & mask_w;

  // Prediction index; len_q high means 32-word lines
  assign idx13_w =
    (sz_w == 3'h0) ? (len_q ? {3'h0, addr_q[17:7]} : {2'h0, addr_q[17:6]}) :
    (sz_w == 3'h1) ? (len_q ? {2'h0, addr_q[18:7]} : {1'b0, addr_q[18:6]}) :
                     (len_q ? {1'b0, addr_q[19:7]} : {1'b0, addr_q[18:6]});
  assign top_w = ENLARGED && (len_q ? (sz_w >= 3'h3) : (sz_w >= 3'h2)) &&
                 (len_q ? addr_q[20] : addr_q[19]);
  assign idx_w = {top_w, idx13_w[`L2WP_PT_IDX_W-2:0]};

  assign cmp_w    = (st_q == l2wp_pkg::L2WP_CMP);
  assign hit_p_w  = tag_hit(ptag_q, addr_q);
  assign hit_a_w  = tag_hit(tag_in_q, addr_q);
  assign pvalid_w = (ptag_q[1:0] != `L2WP_ST_INVALID);
  assign reacc_w  = cmp_w && !hit_p_w && hit_a_w;
  assign upd_w    = reacc_w || (cmp_w && !hit_p_w && !hit_a_w && pvalid_w);

  assign pt.idx    = idx_w;
  assign pt.wr_en  = upd_w;
  assign pt.wr_bit = ~pred_q;

  assign lines_d =
    (st_q == l2wp_pkg::L2WP_PRED) ? (base_w | (pred_q ? slot_w : '0)) :
    reacc_w ? (base_w | (pred_q ? '0 : slot_w)) : l2_index_lines;

  always_comb begin
    st_d = st_q;
    case (st_q)
      l2wp_pkg::L2WP_IDLE:   if (req_evt_w) st_d = l2wp_pkg::L2WP_PRED;
      l2wp_pkg::L2WP_PRED:   st_d = l2wp_pkg::L2WP_ALT;
      l2wp_pkg::L2WP_ALT:    st_d = l2wp_pkg::L2WP_WAIT;
      l2wp_pkg::L2WP_WAIT:   st_d = l2wp_pkg::L2WP_GETP;
      l2wp_pkg::L2WP_GETP:   st_d = l2wp_pkg::L2WP_CMP;
      l2wp_pkg::L2WP_CMP:    st_d = reacc_w ? l2wp_pkg::L2WP_REACC
                                            : l2wp_pkg::L2WP_REPORT;
      l2wp_pkg::L2WP_REACC:  st_d = l2wp_pkg::L2WP_REPORT;
      l2wp_pkg::L2WP_REPORT: st_d = l2wp_pkg::L2WP_IDLE;
      default:               st_d = l2wp_pkg::L2WP_IDLE;
    endcase
  end

  always_ff @(posedge clk_link or negedge lrstn_q) begin
    if (!lrstn_q) begin
      st_q     <= l2wp_pkg::L2WP_IDLE;
      pred_q   <= 1'b0;
      tag_in_q <= '0;
      ptag_q   <= '0;
    end else begin
      st_q     <= st_d;
      tag_in_q <= l2_tag_bus;
      if (st_q == l2wp_pkg::L2WP_IDLE && req_evt_w) begin
        pred_q <= pt.rd_bit;
      end
      if (st_q == l2wp_pkg::L2WP_GETP) begin
        ptag_q <= tag_in_q;
      end
    end
  end

  // Cache port drive; launched on the link clock
  always_ff @(posedge clk_link or negedge lrstn_q) begin
    if (!lrstn_q) begin
      l2_index_lines       <= '0;
      l2_data_way_sel      <= 1'b0;
      l2_tag_way_sel       <= 1'b0;
      l2_tag_index_low_bit <= 1'b0;
      outc_q               <= 2'h0;
      fill_way_q           <= 1'b0;
      done_tgl_q           <= 1'b0;
    end else begin
      l2_index_lines <= lines_d;
      if (st_q == l2wp_pkg::L2WP_PRED) begin
        l2_data_way_sel      <= pred_q;
        l2_tag_way_sel       <= pred_q;
        l2_tag_index_low_bit <= len_q ? 1'b0 :
                                addr_q[`L2WP_TLOW_PA_BIT];
      end else if (st_q == l2wp_pkg::L2WP_ALT) begin
        l2_tag_way_sel <= ~pred_q;
      end else if (reacc_w) begin
        l2_data_way_sel <= ~pred_q;
      end
      if (cmp_w) begin
        outc_q     <= hit_p_w ? 2'(l2wp_pkg::L2WP_HIT_PRED) :
                      hit_a_w ? 2'(l2wp_pkg::L2WP_HIT_ALT) :
                                2'(l2wp_pkg::L2WP_MISS_FILL);
        fill_way_q <= (hit_p_w || !(hit_a_w || pvalid_w)) ? pred_q
                                                          : ~pred_q;
      end
      if (st_q == l2wp_pkg::L2WP_REPORT) begin
        done_tgl_q <= ~done_tgl_q;
      end
    end
  end

  sequence s_probe;
    st_q == l2wp_pkg::L2WP_PRED ##1 st_q == l2wp_pkg::L2WP_ALT;
  endsequence

  sequence s_ways(bit p);
    l2_tag_way_sel == p ##1 l2_tag_way_sel == !p;
  endsequence

  a_tag_toggle: assert property (
    @(posedge clk_link) disable iff (!lrstn_q)
    s_probe |-> s_ways(pred_q))
    else $error("tag way not toggled across both ways");

  a_first_way: assert property (
    @(posedge clk_link) disable iff (!lrstn_q)
    st_q == l2wp_pkg::L2WP_ALT |->
      l2_data_way_sel == pred_q &&
      (|(l2_index_lines & slot_w)) == (pred_q && slot_w != '0))
    else $error("first access not on predicted way");

  a_pred_quiet: assert property (
    @(posedge clk_link) disable iff (!lrstn_q)
    cmp_w && hit_p_w |-> !pt.wr_en ##1 st_q == l2wp_pkg::L2WP_REPORT)
    else $error("predicted hit took corrective action");

  a_alt_reaccess: assert property (
    @(posedge clk_link) disable iff (!lrstn_q)
    cmp_w && !hit_p_w && hit_a_w |-> pt.wr_en && pt.wr_bit != pred_q
      ##1 l2_data_way_sel != pred_q && st_q == l2wp_pkg::L2WP_REACC)
    else $error("other-way hit not re-accessed or recorded");

  a_miss_inval: assert property (
    @(posedge clk_link) disable iff (!lrstn_q)
    cmp_w && !hit_p_w && !hit_a_w && !pvalid_w |->
      !pt.wr_en ##1 fill_way_q == pred_q)
    else $error("invalid predicted way not filled in place");

  a_miss_valid: assert property (
    @(posedge clk_link) disable iff (!lrstn_q)
    cmp_w && !hit_p_w && !hit_a_w && pvalid_w |->
      pt.wr_en ##1 fill_way_q != pred_q)
    else $error("valid predicted way not spared on fill");

  a_tag_low: assert property (
    @(posedge clk_link) disable iff (!lrstn_q)
    st_q == l2wp_pkg::L2WP_ALT && len_q |-> !l2_tag_index_low_bit)
    else $error("tag low bit not negated for 32-word lines");

  a_lines_used: assert property (
    @(posedge clk_link) disable iff (!lrstn_q)
    st_q == l2wp_pkg::L2WP_ALT |-> (l2_index_lines & ~(mask_w | slot_w)) == '0
      && (l2_index_lines & mask_w) == base_w)
    else $error("index lines outside capacity");

  a_idx_pad: assert property (
    @(posedge clk_link) disable iff (!lrstn_q)
    sz_w == 3'h0 |-> idx13_w[12] == 1'b0)
    else $error("prediction index not zero padded");

  a_answer_once: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    resp_valid |=> !resp_valid)
    else $error("answer pulse wider than one cycle");
endmodule

// ---- rtl/l2wp_consts.svh ----
// How it works
// - Port clock is divided from the core clock by a 1/1.5/2/2.5/3 ratio code.
// - Six complementary port clock copies are driven; domains are crossed inside.
// - A boot-time tap sets the port clock phase against the launch clock.
// - Physical address bits 3:0 never reach the cache port.
// - Index lines carry address bits 22:4; data way has its own output.
// - Capacity code 0..5 uses address bits 17:4 up to 22:4 on the lines.
// - Data way bit sits directly above the used index lines for capacity codes 0..4; code 5 has no line for it.
// - Tag index low bit is address bit 6 for 16-word lines, else zero.
// - Tag index is tag way, lines top..3, then the tag index low bit.
// - Way prediction table holds 8K one-bit most-recently-used entries.
// - Enlarged variant holds 16K prediction entries.
// - Prediction bit is the way of the first cache access.
// - Table index is 13 bits chosen by capacity and line length, zero padded; the enlarged variant adds a 14th bit.
// - Both tags are read by toggling the tag way output.
// - Hit in predicted way completes with no corrective action.
// - Hit in other way re-accesses it and points the entry at it.
// - Miss with invalid predicted way fills it and keeps the entry.
// - Miss with valid predicted way fills other way and updates entry.
// - Line length select low means 16 words, high means 32 words.
// - Address bits 39:18 form the 22-bit physical tag compared.
// - Line state 0 is invalid, any nonzero state is valid.
`ifndef L2WP_CONSTS_SVH
`define L2WP_CONSTS_SVH
`define L2WP_PA_W        40
`define L2WP_LINES_W     19
`define L2WP_LINES_LO    4
`define L2WP_LINES_HI    22
`define L2WP_TAG_W       26
`define L2WP_PTAG_HI     39
`define L2WP_PTAG_LO     18
`define L2WP_TB_PTAG_HI  25
`define L2WP_TB_PTAG_LO  4
`define L2WP_ST_INVALID  2'h0
`define L2WP_TLOW_PA_BIT 6
`define L2WP_MIN_LINES   14
`define L2WP_SIZE_MAX    3'h5
`define L2WP_PT_IDX_W    14
`define L2WP_PT_SMALL    8192
`define L2WP_PT_BIG      16384
`define L2WP_DIV_BASE    3'h2
`define L2WP_RATIO_MAX   3'h4
`define L2WP_N_COPIES    6
`define L2WP_TAP_N       4
`endif

// ---- rtl/l2wp_pkg.sv ----
package l2wp_pkg;
  typedef enum logic [2:0] {
    L2WP_IDLE, L2WP_PRED, L2WP_ALT, L2WP_WAIT, L2WP_GETP, L2WP_CMP,
    L2WP_REACC, L2WP_REPORT
  } l2wp_state_t;
  typedef enum logic [1:0] {
    L2WP_HIT_PRED, L2WP_HIT_ALT, L2WP_MISS_FILL
  } l2wp_outcome_t;
endpackage

// ---- rtl/l2wp_pt_if.sv ----
`timescale 1ns/1ps
`include "l2wp_consts.svh"
interface l2wp_pt_if;
  logic [`L2WP_PT_IDX_W-1:0] idx;
  logic                      rd_bit;
  logic                      wr_en;
  logic                      wr_bit;
  modport user  (output idx, output wr_en, output wr_bit, input rd_bit);
  modport tbl   (input idx, input wr_en, input wr_bit, output rd_bit);
endinterface

// ---- rtl/l2wp_pred_table.sv ----
`timescale 1ns/1ps
`include "l2wp_consts.svh"
module l2wp_pred_table #(
  parameter bit ENLARGED = 1'b0
) (
  input wire logic clk_link,
  l2wp_pt_if.tbl   pt
);
  localparam int DEPTH = ENLARGED ? `L2WP_PT_BIG : `L2WP_PT_SMALL;
  localparam int AW    = ENLARGED ? 14 : 13;

  // Entries are never reset; a stale bit only picks the first way read
  // Two-state storage keeps an unknown entry from poisoning the way logic
  bit                mem [0:DEPTH-1];
  logic [AW-1:0]     addr_w;

  assign addr_w    = pt.idx[AW-1:0];
  assign pt.rd_bit = mem[addr_w];

  always_ff @(posedge clk_link) begin
    if (pt.wr_en) begin
      mem[addr_w] <= pt.wr_bit;
    end
  end
endmodule

// ---- rtl/l2wp_clk_gen.sv ----
`timescale 1ns/1ps
`include "l2wp_consts.svh"
module l2wp_clk_gen (
  input  wire logic                     clk_sys,
  input  wire logic                     rstn,
  input  wire logic [2:0]               ratio_sel,
  input  wire logic [1:0]               tap_sel,
  output logic [`L2WP_N_COPIES-1:0]     l2_port_clock,
  output logic [`L2WP_N_COPIES-1:0]     l2_port_clock_n
);
  logic [2:0]             ratio_s1_q, ratio_q;
  logic [1:0]             tap_s1_q, tap_q;
  logic [2:0]             cnt_q, cnt_d;
  logic                   div_q;
  logic [`L2WP_TAP_N-1:0] chain_q;
  logic [2:0]             ratio_w, per_w, hi_w;
  logic                   tapped_w;

  // Straps are quasi-static but still pass two flops
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ratio_s1_q <= 3'h0;
      ratio_q    <= 3'h0;
      tap_s1_q   <= 2'h0;
      tap_q      <= 2'h0;
    end else begin
      ratio_s1_q <= ratio_sel;
      ratio_q    <= ratio_s1_q;
      tap_s1_q   <= tap_sel;
      tap_q      <= tap_s1_q;
    end
  end

  // Period in core cycles is twice the ratio: codes 0..4 give 2..6
  assign ratio_w  = (ratio_q > `L2WP_RATIO_MAX) ? `L2WP_RATIO_MAX : ratio_q;
  assign per_w    = 3'(ratio_w + `L2WP_DIV_BASE);
  assign hi_w     = 3'((per_w + 3'h1) >> 1);
  assign cnt_d    = (cnt_q >= 3'(per_w - 3'h1)) ? 3'h0 : 3'(cnt_q + 3'h1);
  assign tapped_w = chain_q[tap_q];

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_q   <= 3'h0;
      div_q   <= 1'b0;
      chain_q <= '0;
    end else begin
      cnt_q   <= cnt_d;
      div_q   <= (cnt_d < hi_w);
      chain_q <= {chain_q[`L2WP_TAP_N-2:0], div_q};
    end
  end

  genvar g;
  generate
    for (g = 0; g < `L2WP_N_COPIES; g++) begin : g_copy
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          l2_port_clock[g]   <= 1'b0;
          l2_port_clock_n[g] <= 1'b1;
        end else begin
          l2_port_clock[g]   <= tapped_w;
          l2_port_clock_n[g] <= ~tapped_w;
        end
      end
    end
  endgenerate

  a_copies_compl: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    l2_port_clock == ~l2_port_clock_n)
    else $error("port clock copies not complementary");

  a_div_period: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    $rose(div_q) |-> ##1 (!$rose(div_q))[*1] ##0 (cnt_q < per_w))
    else $error("divider counter past period");
endmodule

// ---- bench/l2wp_tag_ram_model.sv ----
`timescale 1ns/1ps
`include "l2wp_consts.svh"
module l2wp_tag_ram_model (
  input  wire logic                   clk_link,
  input  wire logic                   l2_tag_way_sel,
  input  wire logic [`L2WP_TAG_W-1:0] way0_tag,
  input  wire logic [`L2WP_TAG_W-1:0] way1_tag,
  output logic      [`L2WP_TAG_W-1:0] l2_tag_bus
);
  // Registered read: the way chosen before one edge shows after it
  always @(posedge clk_link) begin
    l2_tag_bus <= l2_tag_way_sel ? way1_tag : way0_tag;
  end
endmodule

// ---- bench/l2_cache_index_way_predict_tb.sv ----
`timescale 1ns/1ps
`include "l2wp_consts.svh"
module l2_cache_index_way_predict_tb;
  typedef struct {
    logic [1:0]  out;
    logic        way;
    bit          chk_out;
    logic [39:0] pa;
    int          sz;
    bit          ln;
  } l2wp_exp_t;

  logic        clk_sys;
  logic        rstn;
  logic        clk_link;
  logic [2:0]  l2_clock_ratio_sel;
  logic [1:0]  l2_clock_phase_tap;
  logic [2:0]  l2_capacity_sel;
  logic        l2_line_length_sel;
  logic        req_valid;
  logic [39:0] req_phys_addr;
  logic        req_ready;
  logic        resp_valid;
  logic [1:0]  resp_outcome;
  logic        resp_way;
  logic [5:0]  l2_port_clock;
  logic [5:0]  l2_port_clock_n;
  logic [18:0] l2_index_lines;
  logic        l2_data_way_sel;
  logic        l2_tag_index_low_bit;
  logic        l2_tag_way_sel;
  wire  [25:0] l2_tag_bus;
  logic [25:0] way0_tag;
  logic [25:0] way1_tag;
  logic [39:0] pa_g;
  l2wp_exp_t   exp_q[$];
  int          fail_count = 0;
  int          checks_done = 0;
  int          cyc = 0;

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  initial begin
    clk_link = 1'b0;
    #7;
    forever #16 clk_link = ~clk_link;
  end

  l2wp_top #(.ENLARGED(1'b0)) DUT (
    .clk_sys             (clk_sys),
    .rstn                (rstn),
    .clk_link            (clk_link),
    .l2_clock_ratio_sel  (l2_clock_ratio_sel),
    .l2_clock_phase_tap  (l2_clock_phase_tap),
    .l2_capacity_sel     (l2_capacity_sel),
    .l2_line_length_sel  (l2_line_length_sel),
    .req_valid           (req_valid),
    .req_phys_addr       (req_phys_addr),
    .req_ready           (req_ready),
    .resp_valid          (resp_valid),
    .resp_outcome        (resp_outcome),
    .resp_way            (resp_way),
    .l2_port_clock       (l2_port_clock),
    .l2_port_clock_n     (l2_port_clock_n),
    .l2_index_lines      (l2_index_lines),
    .l2_data_way_sel     (l2_data_way_sel),
    .l2_tag_index_low_bit(l2_tag_index_low_bit),
    .l2_tag_way_sel      (l2_tag_way_sel),
    .l2_tag_bus          (l2_tag_bus)
  );

  l2wp_tag_ram_model tag_ram (
    .clk_link      (clk_link),
    .l2_tag_way_sel(l2_tag_way_sel),
    .way0_tag      (way0_tag),
    .way1_tag      (way1_tag),
    .l2_tag_bus    (l2_tag_bus)
  );

  task automatic chk(input string nm, input logic [39:0] e,
                     input logic [39:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      $display("ERROR timeout expected done seen running");
      summarize();
    end
  end

  // Takes the oldest note whenever an answer is presented
  always @(negedge clk_sys) begin
    l2wp_exp_t   x;
    logic [18:0] m;
    if (resp_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        fail_count++;
        $display("ERROR response expected 0 seen 1");
      end else begin
        x = exp_q.pop_front();
        m = (19'h1 << (14 + x.sz)) - 19'h1;
        if (x.chk_out) chk("outcome", x.out, resp_outcome);
        chk("way", x.way, resp_way);
        chk("lines", x.pa[22:4] & m, l2_index_lines & m);
        chk("tag_low", x.ln ? 1'b0 : x.pa[6], l2_tag_index_low_bit);
        if (x.out != 2'h2) begin
          chk("data_way", x.way, l2_data_way_sel);
          if (x.sz < 5) chk("slot", x.way, l2_index_lines[14+x.sz]);
        end
      end
    end
  end

  // Valid is held a few random cycles into the busy time, where it is ignored
  task automatic req(input logic [25:0] t0, input logic [25:0] t1,
                     input logic [1:0] o, input logic w, input bit c);
    l2wp_exp_t x;
    int        n;
    x.out = o;
    x.way = w;
    x.chk_out = c;
    x.pa = pa_g;
    x.sz = l2_capacity_sel;
    x.ln = l2_line_length_sel;
    way0_tag = t0;
    way1_tag = t1;
    req_phys_addr = pa_g;
    req_valid = 1'b1;
    exp_q.push_back(x);
    repeat (1 + $urandom % 4) @(negedge clk_sys);
    req_valid = 1'b0;
    n = 0;
    while (resp_valid !== 1'b1 && n < 300) begin
      @(negedge clk_sys);
      n++;
    end
  endtask

  task automatic seq;
    logic [25:0] m;
    logic [25:0] o;
    logic [25:0] iv;
    pa_g = 40'({$urandom, $urandom});
    m = {pa_g[39:18], 2'h0, 2'(1 + $urandom % 3)};
    o = m ^ 26'h10;
    iv = {m[25:2], 2'h0};
    req(o, m, 2'h0, 1'b1, 1'b0);
    req(o, m, 2'h0, 1'b1, 1'b1);
    req(m, o, 2'h1, 1'b0, 1'b1);
    req(m, o, 2'h0, 1'b0, 1'b1);
    req(o, o, 2'h2, 1'b1, 1'b1);
    req(o, m, 2'h0, 1'b1, 1'b1);
    req(o, iv, 2'h2, 1'b1, 1'b1);
    req(o, m, 2'h0, 1'b1, 1'b1);
  endtask

  task automatic meas(input logic [2:0] r);
    int   e[$];
    logic p;
    int   i;
    l2_clock_ratio_sel = r;
    l2_clock_phase_tap = 2'($urandom);
    repeat (20) @(negedge clk_sys);
    p = l2_port_clock[0];
    for (i = 0; i < 30; i++) begin
      @(negedge clk_sys);
      if (p === 1'b0 && l2_port_clock[0] === 1'b1) e.push_back(i);
      p = l2_port_clock[0];
    end
    chk("copies", {6{l2_port_clock[0]}}, l2_port_clock);
    chk("copies_n", 6'(~l2_port_clock), l2_port_clock_n);
    if (e.size() < 2) chk("edges", 2, e.size());
    else chk("period", (r > 3'h4 ? 4 : r) + 2, e[1] - e[0]);
  endtask

  initial begin
    int s;
    int l;
    rstn = 1'b0;
    req_valid = 1'b0;
    req_phys_addr = 40'h0;
    l2_clock_ratio_sel = 3'h0;
    l2_clock_phase_tap = 2'h0;
    l2_capacity_sel = 3'h0;
    l2_line_length_sel = 1'b0;
    way0_tag = 26'h0;
    way1_tag = 26'h0;
    pa_g = 40'h0;
    void'($urandom(32'ha34b1c69));
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
    rstn = 1'b1;
    repeat (4) @(posedge clk_link);
    @(negedge clk_sys);
    for (s = 0; s < 5; s++) meas(3'(s));
    meas(3'h7);
    for (s = 0; s < 6; s++) begin
      for (l = 0; l < 2; l++) begin
        l2_capacity_sel = 3'(s);
        l2_line_length_sel = l[0];
        repeat (10) @(negedge clk_sys);
        seq();
      end
    end
    repeat (30) @(negedge clk_sys);
    chk("pending", 0, exp_q.size());
    summarize();
  end
endmodule
